// *** design/sdc_core.sv ***
/*
  Device-side command and data timing of a quad-bank synchronous DRAM,
  with a small flip-flop array standing in for the cell array.
  Assumes the controller drives all inputs from the same clock edge domain.

*/
`timescale 1ns/1ps
module sdc_core
  import sdc_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int BA_W = 2,
  parameter int DQ_W = 16,
  parameter int DQM_W = 2,
  parameter int COL_W = 3,
  parameter int ROW_KEEP = 1,
  parameter int REF_LIMIT = REF_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cke,
  input wire logic cs_b,
  input wire logic ras_b,
  input wire logic cas_b,
  input wire logic we_b,
  input wire logic [BA_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DQM_W-1:0] dqm,
  input wire logic [DQ_W-1:0] dq_in,
  output logic [DQ_W-1:0] dq_out,
  output logic [DQM_W-1:0] dq_oe,
  output logic ready,
  output logic wbuf_ovf
);

  localparam int NB = 1 << BA_W;
  localparam int IDX_W = BA_W + ROW_KEEP + COL_W;
  localparam int DEPTH = 1 << IDX_W;
  localparam int LW = DQ_W / DQM_W;
  localparam int BW = IDX_W + DQM_W + DQ_W;

  typedef struct packed {
    logic cke;
    logic [DQM_W-1:0] dqm;
    sdc_op_t op;
    logic [BA_W-1:0] bank;
    logic [ADDR_W-1:0] row;
    logic [7:0] col0;
    logic [7:0] cnt;
    logic ap;
    logic [ADDR_W-1:0] mode;
    logic [NB-1:0] open;
    logic [NB-1:0][ADDR_W-1:0] rows;
    logic [1:0] pv;
    logic [1:0][DQ_W-1:0] pd;
    logic [DQ_W-1:0] dq_out;
    logic [DQM_W-1:0] dq_oe;
    logic [PAUSE_W-1:0] pause;
    logic [1:0] refs;
    logic ready;
    logic [REF_W-1:0] age;
    logic ovf;
    logic [DEPTH-1:0][DQ_W-1:0] mem;
  } sdc_state_t;

  sdc_state_t s_q;
  sdc_state_t s_d;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Burst length code to column wrap mask
  function automatic logic [7:0] bl_mask(input logic [2:0] code);
    case (code)
      3'h0: bl_mask = 8'h00;
      3'h1: bl_mask = 8'h01;
      3'h2: bl_mask = 8'h03;
      3'h3: bl_mask = 8'h07;
      3'h7: bl_mask = 8'hff;
      default: bl_mask = 8'h00;
    endcase
  endfunction

  // Column of burst word, sequential or interleaved
  function automatic logic [7:0] burst_col(input logic [7:0] c0, input logic [7:0] n,
                                           input logic [7:0] msk, input logic il);
    logic [7:0] low;
    low = il ? (c0 ^ n) : 8'(c0 + n);
    burst_col = (c0 & ~msk) | (low & msk);
  endfunction

  // Array index from bank, row and column
  function automatic logic [IDX_W-1:0] mk_idx(input logic [BA_W-1:0] b,
                                              input logic [ADDR_W-1:0] r,
                                              input logic [7:0] c);
    mk_idx = {b, r[ROW_KEEP-1:0], c[COL_W-1:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Write buffer between pins and array

  logic act;
  logic [3:0] cmd;
  logic [7:0] msk;
  logic fp;
  logic il;
  logic cl3;
  logic issue;
  logic i_rd;
  logic i_last;
  logic i_ap;
  logic [BA_W-1:0] i_bank;
  logic [ADDR_W-1:0] i_row;
  logic [7:0] i_col;
  logic [7:0] i_cnt;
  logic [IDX_W-1:0] i_idx;
  logic push;
  logic b_in_ready;
  logic b_out_valid;
  logic b_out_ready;
  logic [BW-1:0] b_in_data;
  logic [BW-1:0] b_out_data;
  logic [IDX_W-1:0] w_idx;
  logic [DQM_W-1:0] w_be;
  logic [DQ_W-1:0] w_data;

  sdc_buf2 #(
    .WIDTH(BW)
  ) u_wbuf (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(push),
    .in_ready(b_in_ready),
    .in_data(b_in_data),
    .out_valid(b_out_valid),
    .out_ready(b_out_ready),
    .out_data(b_out_data)
  );

  assign {w_idx, w_be, w_data} = b_out_data;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    s_d = s_q;
    act = s_q.cke;
    cmd = {cs_b, ras_b, cas_b, we_b};
    msk = bl_mask(s_q.mode[MR_BL_LSB +: 3]);
    fp = (s_q.mode[MR_BL_LSB +: 3] == MR_BL_PAGE);
    il = s_q.mode[MR_BT_BIT];
    cl3 = (s_q.mode[MR_CL_LSB +: 3] == MR_CL3);
    issue = 1'b0;
    i_rd = 1'b0;
    i_ap = s_q.ap;
    i_bank = s_q.bank;
    i_row = s_q.row;
    i_cnt = s_q.cnt;
    i_col = burst_col(s_q.col0, s_q.cnt, msk, il);

    // Clock enable takes effect one clock later
    s_d.cke = cke;

    // Power-up pause and refresh window tracking
    if (s_q.pause != PAUSE_W'(PAUSE_CYC)) begin
      s_d.pause = s_q.pause + 12'h001;
    end
    if (s_q.op == SDC_OP_SELF) begin
      s_d.age = '0;
    end else if (s_q.age != REF_W'(REF_LIMIT)) begin
      s_d.age = s_q.age + 22'h000001;
    end else begin
      s_d.refs = 2'h0;
    end

    if (act) begin
      s_d.dqm = dqm;
      // Running burst yields one word per clock
      if (s_q.op == SDC_OP_READ || s_q.op == SDC_OP_WRITE) begin
        issue = 1'b1;
        i_rd = (s_q.op == SDC_OP_READ);
      end
      if (s_q.op == SDC_OP_SELF) begin
        s_d.op = SDC_OP_IDLE;
      end else if (!cs_b) begin
        case (cmd)
          CMD_RD, CMD_WR: begin
            // New column command on any clock
            if (s_q.open[ba]) begin
              issue = 1'b1;
              i_rd = (cmd == CMD_RD);
              i_bank = ba;
              i_row = s_q.rows[ba];
              i_cnt = 8'h00;
              i_ap = addr[AP_BIT];
              i_col = burst_col(addr[7:0], 8'h00, msk, il);
              s_d.bank = ba;
              s_d.row = s_q.rows[ba];
              s_d.col0 = addr[7:0];
              s_d.ap = addr[AP_BIT];
            end
          end
          CMD_PRE: begin
            // Precharge into own bank stops the word stream
            if (addr[AP_BIT] || ba == s_q.bank) begin
              issue = 1'b0;
              if (s_q.op != SDC_OP_IDLE) begin
                s_d.op = SDC_OP_IDLE;
              end
            end
            if (addr[AP_BIT]) begin
              s_d.open = '0;
            end else begin
              s_d.open[ba] = 1'b0;
            end
          end
          CMD_BST: begin
            issue = 1'b0;
            s_d.op = SDC_OP_IDLE;
          end
          CMD_ACT: begin
            s_d.open[ba] = 1'b1;
            s_d.rows[ba] = addr;
          end
          CMD_LMR: begin
            s_d.mode = addr;
          end
          CMD_REF: begin
            if (!cke) begin
              s_d.op = SDC_OP_SELF;
            end else begin
              s_d.age = '0;
              if (s_q.pause == PAUSE_W'(PAUSE_CYC) && s_q.refs != INIT_REFS) begin
                s_d.refs = s_q.refs + 2'h1;
              end
            end
          end
          default: begin
          end
        endcase
      end
      i_last = !fp && (i_cnt == msk);
      // Burst bookkeeping and auto precharge at the end
      if (issue) begin
        s_d.op = i_rd ? SDC_OP_READ : SDC_OP_WRITE;
        s_d.cnt = i_cnt + 8'h01;
        if (i_last) begin
          s_d.op = SDC_OP_IDLE;
          if (i_ap) begin
            s_d.open[i_bank] = 1'b0;
          end
        end
      end
    end else begin
      i_last = 1'b0;
    end

    i_idx = mk_idx(i_bank, i_row, i_col);

    // Read pipeline, frozen while the internal clock is stopped
    if (act) begin
      s_d.pv[0] = issue & i_rd;
      s_d.pd[0] = s_q.mem[i_idx];
      s_d.pv[1] = s_q.pv[0];
      s_d.pd[1] = s_q.pd[0];
      // Latency select; mask sampled last edge floats lanes
      s_d.dq_out = cl3 ? s_q.pd[1] : s_q.pd[0];
      s_d.dq_oe = (cl3 ? s_q.pv[1] : s_q.pv[0]) ? ~s_q.dqm : '0;
    end

    // Write word taken on the command edge, masked lanes dropped
    push = act & issue & ~i_rd & (dqm != '1);
    b_in_data = {i_idx, ~dqm, dq_in};
    if (push && !b_in_ready) begin
      s_d.ovf = 1'b1;
    end

    // Array port shared; a read issue stalls the buffer drain
    b_out_ready = ~(act & issue & i_rd);
    if (b_out_valid && b_out_ready) begin
      for (int l = 0; l < DQM_W; l++) begin
        if (w_be[l]) begin
          s_d.mem[w_idx][l*LW +: LW] = w_data[l*LW +: LW];
        end
      end
    end

    s_d.ready = (s_q.pause == PAUSE_W'(PAUSE_CYC)) && (s_q.refs == INIT_REFS);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.op <= SDC_OP_IDLE;
      s_q.mode <= ADDR_W'(MR_RESET);
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign dq_out = s_q.dq_out;
  assign dq_oe = s_q.dq_oe;
  assign ready = s_q.ready;
  assign wbuf_ovf = s_q.ovf;

endmodule

// *** design/sdc_pkg.sv ***
/*
  Shared constants for the synchronous DRAM command and data timing core:
  command codes, mode word fields, reset values and clock-counted delays.
  Assumes a single 40 MHz clock shared with the memory controller.
*/
package sdc_pkg;

  // Clock rate
  localparam int CLK_MHZ = 40;

  // Command code {cs_b, ras_b, cas_b, we_b}
  localparam logic [3:0] CMD_LMR = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_BST = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;

  // Mode word fields
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam logic [2:0] MR_CL3 = 3'h3;
  localparam logic [2:0] MR_BL_PAGE = 3'h7;
  localparam logic [11:0] MR_RESET = 12'h030;

  // Address bit selecting auto precharge or all banks
  localparam int AP_BIT = 10;

  // Clock-counted delays
  localparam int CKE_LAT = 1;
  localparam int DQZ_LAT = 2;
  localparam int MRD_CYC = 2;

  // Power-up pause and refresh window
  localparam int PAUSE_US = 100;
  localparam int PAUSE_CYC = PAUSE_US * CLK_MHZ;
  localparam int PAUSE_W = 12;
  localparam int REF_MS = 64;
  localparam int REF_CYC = REF_MS * 1000 * CLK_MHZ;
  localparam int REF_W = 22;
  localparam logic [1:0] INIT_REFS = 2'h2;

  // Burst activity
  typedef enum logic [3:0] {
    SDC_OP_IDLE = 4'h1,
    SDC_OP_READ = 4'h2,
    SDC_OP_WRITE = 4'h4,
    SDC_OP_SELF = 4'h8
  } sdc_op_t;

endpackage

// *** design/sdc_buf2.sv ***
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module sdc_buf2 #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  typedef struct packed {
    logic [1:0][WIDTH-1:0] slot;
    logic rd;
    logic [1:0] cnt;
  } sdc_buf_t;

  sdc_buf_t b_q;
  sdc_buf_t b_d;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////
  // Handshake terms
  assign in_ready = (b_q.cnt != 2'h2);
  assign out_valid = (b_q.cnt != 2'h0);
  assign out_data = b_q.slot[b_q.rd];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Next state
  always_comb begin
    b_d = b_q;
    if (push) begin
      b_d.slot[b_q.rd ^ b_q.cnt[0]] = in_data;
    end
    if (pop) begin
      b_d.rd = ~b_q.rd;
    end
    b_d.cnt = b_q.cnt + {1'b0, push} - {1'b0, pop};
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      b_q <= '0;
    end else begin
      b_q <= b_d;
    end
  end

endmodule

// *** tb/sdc_core_assertions.sv ***
/*
  Port-level checks of the DRAM timing core.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module sdc_core_assertions
  import sdc_pkg::*;
#(
  parameter int REF_LIMIT = REF_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cke,
  input wire logic cs_b,
  input wire logic ras_b,
  input wire logic cas_b,
  input wire logic we_b,
  input wire logic [11:0] addr,
  input wire logic [1:0] dqm,
  input wire logic [15:0] dq_out,
  input wire logic [1:0] dq_oe,
  input wire logic ready,
  input wire logic wbuf_ovf
);
  logic [3:0] cmd;
  logic [31:0] idle_q;
  logic [31:0] idle_d;

  ////////////////////////////////////////////////////////////////////////////
  // Command code on the pins
  assign cmd = {cs_b, ras_b, cas_b, we_b};

  // Cycles since the last refresh or clock-enable drop
  always_comb begin
    idle_d = idle_q + 32'h1;
    if (!rst_b || !cke || cmd == CMD_REF) begin
      idle_d = 32'h0;
    end
  end

  always_ff @(posedge clk) begin
    idle_q <= idle_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_rst_quiet: assert property ($rose(rst_b) |-> dq_oe == 2'h0 && !ready && !wbuf_ovf)
    else $error("outputs not idle after reset");
  a_ready_cause: assert property ($rose(ready) |->
    $past(cmd == CMD_REF) || $past(cmd == CMD_REF, 2))
    else $error("ready rose without a refresh");
  a_ready_lapse: assert property (idle_q > REF_LIMIT + 8 |-> !ready)
    else $error("ready held past the refresh window");
  a_mask_lo: assert property ($past(cke) && cke && dqm[0] ##1 cke |=> !dq_oe[0])
    else $error("masked low lane still driven");
  a_mask_hi: assert property (dqm[1] && $past(cke) && cke ##1 cke |-> ##1 dq_oe[1] == 1'b0)
    else $error("masked high lane still driven");
  a_pre_float: assert property (cmd == CMD_PRE && addr[AP_BIT] && $past(cke) && cke
    ##1 ((cs_b || cmd == CMD_NOP) && cke) [*2] |=> dq_oe == 2'h0)
    else $error("outputs driven after precharge");
  a_cke_freeze: assert property (!cke |=> ##1 $stable(dq_out) && $stable(dq_oe))
    else $error("outputs moved while clock suspended");
  a_oe_cause: assert property ($rose(dq_oe[0]) && $past(cke, 2) && $past(cke, 3)
    && $past(cke, 4) && !$past(dqm[0], 3)
    |-> $past(cmd == CMD_RD, 2) || $past(cmd == CMD_RD, 3))
    else $error("read data without a read");
endmodule

bind sdc_core sdc_core_assertions #(.REF_LIMIT(REF_LIMIT)) chk_u (
  .clk(clk),
  .rst_b(rst_b),
  .cke(cke),
  .cs_b(cs_b),
  .ras_b(ras_b),
  .cas_b(cas_b),
  .we_b(we_b),
  .addr(addr),
  .dqm(dqm),
  .dq_out(dq_out),
  .dq_oe(dq_oe),
  .ready(ready),
  .wbuf_ovf(wbuf_ovf)
);

// *** tb/sdc_ctrl_model.sv ***
/*
  Behavioural memory controller driving command, mask and write data pins.
  Assumes the bench calls its tasks and the clock never stops.
*/
`timescale 1ns/1ps
module sdc_ctrl_model
  import sdc_pkg::*;
(
  input wire logic clk,
  output logic cke,
  output logic cs_b,
  output logic ras_b,
  output logic cas_b,
  output logic we_b,
  output logic [1:0] ba,
  output logic [11:0] addr,
  output logic [1:0] dqm,
  output logic [15:0] dq_in
);
  // Pins idle with the clock enabled
  initial begin
    cke = 1'b1;
    {cs_b, ras_b, cas_b, we_b} = CMD_NOP;
    {ba, addr} = 14'h0;
    dqm = 2'h0;
    dq_in = 16'h0;
  end

  // One command per falling edge, write data beside it
  task automatic cmd(input logic [3:0] c, input logic [13:0] a, input logic [1:0] m,
      input logic [15:0] d);
    @(negedge clk);
    {cs_b, ras_b, cas_b, we_b} = c;
    {ba, addr} = a;
    dqm = m;
    dq_in = d;
  endtask

  // Idle clocks, released data lines keep changing
  task automatic nop(input int n);
    repeat (n) begin
      cmd(CMD_NOP, 14'h0, 2'h0, ~dq_in);
    end
  endtask

  // Clock enable change with a NOP
  task automatic hold(input logic k);
    cmd(CMD_NOP, 14'h0, 2'h0, ~dq_in);
    cke = k;
  endtask
endmodule

// *** tb/tb.sv ***
/*
  Self-checking bench for the DRAM timing core.
  Assumes the controller model drives all pins at falling edges.
*/
`timescale 1ns/1ps
module tb;
  import sdc_pkg::*;
  localparam int REF_LIM = 600;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cke, cs_b, ras_b, cas_b, we_b, ready, wbuf_ovf;
  logic [1:0] ba;
  logic [1:0] dqm;
  logic [1:0] dq_oe;
  logic [11:0] addr;
  logic [15:0] dq_in;
  logic [15:0] dq_out;
  int err_count = 0;
  int check_count = 0;

  // Clock at 40 MHz
  always #12.5 clk = ~clk;

  sdc_core #(.REF_LIMIT(REF_LIM)) dut_u (
    .clk(clk),
    .rst_b(rst_b),
    .cke(cke),
    .cs_b(cs_b),
    .ras_b(ras_b),
    .cas_b(cas_b),
    .we_b(we_b),
    .ba(ba),
    .addr(addr),
    .dqm(dqm),
    .dq_in(dq_in),
    .dq_out(dq_out),
    .dq_oe(dq_oe),
    .ready(ready),
    .wbuf_ovf(wbuf_ovf)
  );
  sdc_ctrl_model ctl_u (
    .clk(clk),
    .cke(cke),
    .cs_b(cs_b),
    .ras_b(ras_b),
    .cas_b(cas_b),
    .we_b(we_b),
    .ba(ba),
    .addr(addr),
    .dqm(dqm),
    .dq_in(dq_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One clock on, then compare lane enables, and data when both lanes drive
  task automatic see(input logic [15:0] d, input logic [1:0] oe);
    ctl_u.nop(1);
    check(16'(dq_oe), 16'(oe));
    if (oe == 2'h3) check(dq_out, d);
  endtask

  // Two refreshes a few clocks apart
  task automatic wake();
    repeat (2) begin
      ctl_u.cmd(CMD_REF, 14'h0, 2'h0, 16'h0);
      ctl_u.nop(3);
    end
    check(16'(ready), 16'h1);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_init();
    ctl_u.nop(PAUSE_CYC + 2);
    check(16'(ready), 16'h0);
    wake();
    ctl_u.cmd(CMD_LMR, 14'h0031, 2'h0, 16'h0);
    ctl_u.nop(2);
    $display("t_init done");
  endtask

  task automatic t_wr_rd();
    ctl_u.cmd(CMD_ACT, 14'h1000, 2'h0, 16'h0);
    ctl_u.nop(1);
    ctl_u.cmd(CMD_WR, 14'h1002, 2'h0, 16'h5555);
    ctl_u.cmd(CMD_WR, 14'h1000, 2'h0, 16'h1111);
    ctl_u.cmd(CMD_WR, 14'h1002, 2'h2, 16'h2222);
    ctl_u.cmd(CMD_NOP, 14'h0, 2'h0, 16'h3333);
    ctl_u.nop(4);
    check(16'(wbuf_ovf), 16'h0);
    ctl_u.cmd(CMD_RD, 14'h1000, 2'h0, 16'h0);
    ctl_u.cmd(CMD_RD, 14'h1002, 2'h0, 16'h0);
    ctl_u.nop(1);
    see(16'h1111, 2'h3);
    see(16'h5522, 2'h3);
    see(16'h3333, 2'h3);
    see(16'h0, 2'h0);
    $display("t_wr_rd done");
  endtask

  task automatic t_mask();
    ctl_u.cmd(CMD_RD, 14'h1002, 2'h0, 16'h0);
    ctl_u.nop(1);
    ctl_u.cmd(CMD_NOP, 14'h0, 2'h1, 16'h0);
    see(16'h5522, 2'h3);
    see(16'h0, 2'h2);
    // Upper lane masked on the second word
    ctl_u.cmd(CMD_RD, 14'h1000, 2'h0, 16'h0);
    ctl_u.nop(1);
    ctl_u.cmd(CMD_NOP, 14'h0, 2'h2, 16'h0);
    see(16'h1111, 2'h3);
    see(16'h0, 2'h1);
    $display("t_mask done");
  endtask

  task automatic t_cut();
    ctl_u.cmd(CMD_RD, 14'h1002, 2'h0, 16'h0);
    ctl_u.cmd(CMD_PRE, 14'h0400, 2'h0, 16'h0);
    ctl_u.nop(1);
    see(16'h5522, 2'h3);
    see(16'h0, 2'h0);
    $display("t_cut done");
  endtask

  task automatic t_cke();
    ctl_u.cmd(CMD_ACT, 14'h1000, 2'h0, 16'h0);
    ctl_u.nop(1);
    ctl_u.cmd(CMD_RD, 14'h1002, 2'h0, 16'h0);
    ctl_u.nop(1);
    ctl_u.hold(1'b0);
    ctl_u.hold(1'b1);
    check(dq_out, 16'h5522);
    see(16'h5522, 2'h3);
    see(16'h3333, 2'h3);
    ctl_u.nop(2);
    ctl_u.cmd(CMD_PRE, 14'h0400, 2'h0, 16'h0);
    $display("t_cke done");
  endtask

  task automatic t_lapse();
    ctl_u.nop(REF_LIM + 50);
    check(16'(ready), 16'h0);
    wake();
    $display("t_lapse done");
  endtask

  // Auto precharge write closes the bank; burst terminate cuts write and read
  task automatic t_ap();
    ctl_u.cmd(CMD_ACT, 14'h1000, 2'h0, 16'h0);
    ctl_u.nop(1);
    ctl_u.cmd(CMD_WR, 14'h1404, 2'h0, 16'h4444);
    ctl_u.cmd(CMD_NOP, 14'h0, 2'h0, 16'h6666);
    ctl_u.nop(5);
    ctl_u.cmd(CMD_RD, 14'h1004, 2'h0, 16'h0);
    ctl_u.nop(2);
    see(16'h0, 2'h0);
    see(16'h0, 2'h0);
    ctl_u.cmd(CMD_ACT, 14'h1000, 2'h0, 16'h0);
    ctl_u.nop(1);
    ctl_u.cmd(CMD_WR, 14'h1006, 2'h0, 16'h7777);
    ctl_u.cmd(CMD_BST, 14'h0, 2'h0, 16'h8888);
    ctl_u.nop(2);
    ctl_u.cmd(CMD_RD, 14'h1007, 2'h0, 16'h0);
    ctl_u.cmd(CMD_BST, 14'h0, 2'h0, 16'h0);
    ctl_u.nop(1);
    see(16'h0, 2'h3);
    see(16'h0, 2'h0);
    $display("t_ap done");
  endtask

  // Latency two, interleaved order, four-word burst
  task automatic t_mode();
    ctl_u.cmd(CMD_PRE, 14'h0400, 2'h0, 16'h0);
    ctl_u.nop(1);
    ctl_u.cmd(CMD_LMR, 14'h002a, 2'h0, 16'h0);
    ctl_u.nop(2);
    ctl_u.cmd(CMD_ACT, 14'h1000, 2'h0, 16'h0);
    ctl_u.nop(1);
    ctl_u.cmd(CMD_RD, 14'h1005, 2'h0, 16'h0);
    ctl_u.nop(1);
    see(16'h6666, 2'h3);
    see(16'h4444, 2'h3);
    see(16'h0, 2'h3);
    see(16'h7777, 2'h3);
    see(16'h0, 2'h0);
    $display("t_mode done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence after a reset of ten clocks
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    t_init();
    t_wr_rd();
    t_mask();
    t_cut();
    t_cke();
    t_lapse();
    t_ap();
    t_mode();
    test_done();
  end

  // Watchdog at about 8000 clocks
  initial begin
    #200000;
    err_count++;
    test_done();
  end
endmodule
